// >>> xmd_pkg.sv
`default_nettype none
package xmd_pkg;
  localparam int unsigned XMD_ADDR_W = 16;
  localparam logic [7:0] XMD_BYTE_CLEAR = 8'h00;
  localparam logic [7:0] XMD_BYTE_SET = 8'hFF;
  localparam logic [7:0] XMD_ONE = 8'h01;
  localparam logic [3:0] XMD_BCD_MAX = 4'h9;
  localparam logic [3:0] XMD_BCD_ADJ = 4'h6;
  // Register byte offsets on the bus.
  localparam logic [7:0] XMD_REG_CTRL = 8'h00;
  localparam logic [7:0] XMD_REG_ACC = 8'h04;
  localparam logic [7:0] XMD_REG_FLAGS = 8'h08;
  localparam logic [7:0] XMD_REG_STATUS = 8'h0C;
  localparam logic [7:0] XMD_REG_OPCNT = 8'h10;
  localparam int unsigned XMD_CTRL_EN_BIT = 0;
  localparam int unsigned XMD_STAT_BUSY_BIT = 0;
  localparam int unsigned XMD_STAT_SKIP_BIT = 1;
  localparam logic XMD_CTRL_EN_RST = 1'b1;
  localparam logic [1:0] XMD_RESP_OKAY = 2'h0;
  localparam logic [1:0] XMD_RESP_SLVERR = 2'h2;
  localparam int unsigned XMD_SKIP_CYCLES = 3;

  typedef enum logic [4:0] {
    FAR_CLEAR_OP, FAR_CLEAR_BIT_OP, FAR_SET_OP, FAR_SET_BIT_OP,
    FAR_INVERT_OP, FAR_INVERT_TO_ACC_OP, FAR_DECIMAL_ADJUST_OP,
    FAR_DECREMENT_OP, FAR_DECREMENT_TO_ACC_OP, FAR_INCREMENT_OP, FAR_INCREMENT_TO_ACC_OP,
    FAR_MOVE_TO_ACC_OP, FAR_MOVE_TO_MEM_OP, FAR_BITWISE_UNION_OP, FAR_BITWISE_UNION_TO_MEM_OP,
    FAR_ROTATE_LEFT_OP, FAR_ROTATE_LEFT_TO_ACC_OP, FAR_ROTATE_LEFT_THRU_CARRY_OP,
    FAR_ROTATE_LEFT_THRU_CARRY_ACC_OP, FAR_ROTATE_RIGHT_OP, FAR_ROTATE_RIGHT_TO_ACC_OP,
    FAR_ROTATE_RIGHT_THRU_CARRY_OP, FAR_ROTATE_RIGHT_THRU_CARRY_ACC_OP,
    FAR_SUBTRACT_BORROW_OP, FAR_SUBTRACT_BORROW_TO_MEM_OP,
    FAR_DECREMENT_SKIP_ZERO_OP, FAR_DECREMENT_SKIP_ZERO_ACC_OP, FAR_INCREMENT_SKIP_ZERO_OP
  } xmd_op_t;

  typedef struct packed {
    logic chained_zero_flag;
    logic signed_compare_flag;
    logic signed_range_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } xmd_flags_t;

  localparam xmd_flags_t XMD_FLAGS_RST = '0;
  localparam logic [7:0] XMD_ACC_RST = 8'h00;

  typedef struct packed {
    xmd_op_t op;
    logic [2:0] bit_sel;
    logic [XMD_ADDR_W-1:0] addr;
    logic [7:0] mem_data;
  } xmd_req_t;

  typedef struct packed {
    logic we;
    logic [XMD_ADDR_W-1:0] addr;
    logic [7:0] data;
  } xmd_mem_wr_t;
endpackage
`default_nettype wire

// >>> xmd_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module xmd_datapath (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire xmd_pkg::xmd_req_t op_req_i,
  output xmd_pkg::xmd_mem_wr_t mem_wr_o,
  output logic done_o,
  output logic skip_next_o,
  output logic [7:0] acc_o,
  output xmd_pkg::xmd_flags_t flags_o,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import xmd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    return v == XMD_BYTE_CLEAR;
  endfunction

  function automatic logic is_skip_op(input xmd_op_t o);
    return (o == FAR_DECREMENT_SKIP_ZERO_OP) || (o == FAR_DECREMENT_SKIP_ZERO_ACC_OP) ||
           (o == FAR_INCREMENT_SKIP_ZERO_OP);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == XMD_REG_CTRL) || (a == XMD_REG_ACC) || (a == XMD_REG_FLAGS) ||
           (a == XMD_REG_STATUS) || (a == XMD_REG_OPCNT);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_EXEC = 4'h2,
    S_DUMMY1 = 4'h4,
    S_DUMMY2 = 4'h8
  } xmd_state_t;

  xmd_state_t state_q;
  xmd_state_t state_d;
  xmd_req_t req_q;
  logic [7:0] acc_q;
  xmd_flags_t flags_q;
  logic en_q;
  logic last_skip_q;
  logic [31:0] opcnt_q;
  logic op_take;
  logic wr_fire;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;

  // Result of the operation latched in req_q.
  logic [7:0] res;
  logic wr_acc;
  logic wr_mem;
  logic skip_n;
  xmd_flags_t flags_n;

  assign op_take = op_valid_i && op_ready_o;

  // Mask helper used by the single-bit forms, plus subtract and decimal-adjust helpers.
  logic [7:0] bit_mask;
  logic [8:0] sub_full;
  logic [4:0] sub_half;
  logic [8:0] daa_sum;
  logic lo_adj;
  logic hi_adj;

  always_comb begin
    bit_mask = XMD_ONE << req_q.bit_sel;
    sub_full = {1'b0, acc_q} - {1'b0, req_q.mem_data} - {8'h00, ~flags_q.carry_flag};
    sub_half = {1'b0, acc_q[3:0]} - {1'b0, req_q.mem_data[3:0]} - {4'h0, ~flags_q.carry_flag};
    lo_adj = (acc_q[3:0] > XMD_BCD_MAX) || flags_q.half_carry_flag;
    hi_adj = (acc_q[7:4] > XMD_BCD_MAX) || flags_q.carry_flag;
    daa_sum = {1'b0, acc_q} + {1'b0, (hi_adj ? XMD_BCD_ADJ : 4'h0), (lo_adj ? XMD_BCD_ADJ : 4'h0)};
  end

  always_comb begin
    res = req_q.mem_data;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    skip_n = 1'b0;
    flags_n = flags_q;
    unique case (req_q.op)
      FAR_CLEAR_OP: begin
        res = XMD_BYTE_CLEAR;
        wr_mem = 1'b1;
      end
      FAR_CLEAR_BIT_OP: begin
        res = req_q.mem_data & ~bit_mask;
        wr_mem = 1'b1;
      end
      FAR_SET_OP: begin
        res = XMD_BYTE_SET;
        wr_mem = 1'b1;
      end
      FAR_SET_BIT_OP: begin
        res = req_q.mem_data | bit_mask;
        wr_mem = 1'b1;
      end
      FAR_INVERT_OP, FAR_INVERT_TO_ACC_OP: begin
        res = ~req_q.mem_data;
        wr_mem = (req_q.op == FAR_INVERT_OP);
        wr_acc = !wr_mem;
        flags_n.zero_flag = is_zero(res);
      end
      FAR_DECIMAL_ADJUST_OP: begin
        res = daa_sum[7:0];
        wr_mem = 1'b1;
        flags_n.carry_flag = flags_q.carry_flag | daa_sum[8];
      end
      FAR_DECREMENT_OP, FAR_DECREMENT_TO_ACC_OP: begin
        res = req_q.mem_data - XMD_ONE;
        wr_mem = (req_q.op == FAR_DECREMENT_OP);
        wr_acc = !wr_mem;
        flags_n.zero_flag = is_zero(res);
      end
      FAR_INCREMENT_OP, FAR_INCREMENT_TO_ACC_OP: begin
        res = req_q.mem_data + XMD_ONE;
        wr_mem = (req_q.op == FAR_INCREMENT_OP);
        wr_acc = !wr_mem;
        flags_n.zero_flag = is_zero(res);
      end
      FAR_MOVE_TO_ACC_OP: begin
        res = req_q.mem_data;
        wr_acc = 1'b1;
      end
      FAR_MOVE_TO_MEM_OP: begin
        res = acc_q;
        wr_mem = 1'b1;
      end
      FAR_BITWISE_UNION_OP, FAR_BITWISE_UNION_TO_MEM_OP: begin
        res = acc_q | req_q.mem_data;
        wr_mem = (req_q.op == FAR_BITWISE_UNION_TO_MEM_OP);
        wr_acc = !wr_mem;
        flags_n.zero_flag = is_zero(res);
      end
      FAR_ROTATE_LEFT_OP, FAR_ROTATE_LEFT_TO_ACC_OP: begin
        res = {req_q.mem_data[6:0], req_q.mem_data[7]};
        wr_mem = (req_q.op == FAR_ROTATE_LEFT_OP);
        wr_acc = !wr_mem;
      end
      FAR_ROTATE_LEFT_THRU_CARRY_OP, FAR_ROTATE_LEFT_THRU_CARRY_ACC_OP: begin
        res = {req_q.mem_data[6:0], flags_q.carry_flag};
        wr_mem = (req_q.op == FAR_ROTATE_LEFT_THRU_CARRY_OP);
        wr_acc = !wr_mem;
        flags_n.carry_flag = req_q.mem_data[7];
      end
      FAR_ROTATE_RIGHT_OP, FAR_ROTATE_RIGHT_TO_ACC_OP: begin
        res = {req_q.mem_data[0], req_q.mem_data[7:1]};
        wr_mem = (req_q.op == FAR_ROTATE_RIGHT_OP);
        wr_acc = !wr_mem;
      end
      FAR_ROTATE_RIGHT_THRU_CARRY_OP, FAR_ROTATE_RIGHT_THRU_CARRY_ACC_OP: begin
        res = {flags_q.carry_flag, req_q.mem_data[7:1]};
        wr_mem = (req_q.op == FAR_ROTATE_RIGHT_THRU_CARRY_OP);
        wr_acc = !wr_mem;
        flags_n.carry_flag = req_q.mem_data[0];
      end
      FAR_SUBTRACT_BORROW_OP, FAR_SUBTRACT_BORROW_TO_MEM_OP: begin
        res = sub_full[7:0];
        wr_mem = (req_q.op == FAR_SUBTRACT_BORROW_TO_MEM_OP);
        wr_acc = !wr_mem;
        flags_n.carry_flag = !sub_full[8];
        flags_n.half_carry_flag = !sub_half[4];
        flags_n.signed_range_flag = (acc_q[7] != req_q.mem_data[7]) && (sub_full[7] != acc_q[7]);
        flags_n.signed_compare_flag = flags_n.signed_range_flag ^ sub_full[7];
        flags_n.zero_flag = is_zero(res);
        // Chaining lets a multi-byte subtract report zero only if every byte was zero.
        flags_n.chained_zero_flag = is_zero(res) && flags_q.chained_zero_flag;
      end
      FAR_DECREMENT_SKIP_ZERO_OP, FAR_DECREMENT_SKIP_ZERO_ACC_OP: begin
        res = req_q.mem_data - XMD_ONE;
        wr_mem = (req_q.op == FAR_DECREMENT_SKIP_ZERO_OP);
        wr_acc = !wr_mem;
        skip_n = is_zero(res);
      end
      FAR_INCREMENT_SKIP_ZERO_OP: begin
        res = req_q.mem_data + XMD_ONE;
        wr_mem = 1'b1;
        skip_n = is_zero(res);
      end
      default: begin
        res = req_q.mem_data;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (op_take) state_d = S_EXEC;
      S_EXEC: state_d = is_skip_op(req_q.op) ? S_DUMMY1 : S_IDLE;
      S_DUMMY1: state_d = S_DUMMY2;
      S_DUMMY2: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_ready_o <= 1'b0;
    end else begin
      op_ready_o <= (state_d == S_IDLE) && en_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_q <= '0;
    end else if (op_take) begin
      req_q <= op_req_i;
    end
  end

  // ----------------------------------------------------------------
  // Results towards memory and the sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_wr_o <= '0;
      done_o <= 1'b0;
      skip_next_o <= 1'b0;
      last_skip_q <= 1'b0;
    end else begin
      mem_wr_o.we <= (state_q == S_EXEC) && wr_mem;
      mem_wr_o.addr <= req_q.addr;
      mem_wr_o.data <= res;
      done_o <= ((state_q == S_EXEC) && !is_skip_op(req_q.op)) || (state_q == S_DUMMY2);
      skip_next_o <= (state_q == S_DUMMY2) && last_skip_q;
      if (state_q == S_EXEC) begin
        last_skip_q <= skip_n;
      end
    end
  end

  // The datapath owns accumulator and flags in the execute cycle; bus writes wait it out.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= XMD_ACC_RST;
      flags_q <= XMD_FLAGS_RST;
      en_q <= XMD_CTRL_EN_RST;
    end else if (state_q == S_EXEC) begin
      if (wr_acc) begin
        acc_q <= res;
      end
      flags_q <= flags_n;
    end else if (wr_fire && wr_strb_q[0]) begin
      if (wr_addr_q == XMD_REG_ACC) acc_q <= wr_data_q[7:0];
      if (wr_addr_q == XMD_REG_FLAGS) flags_q <= wr_data_q[5:0];
      if (wr_addr_q == XMD_REG_CTRL) en_q <= wr_data_q[XMD_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opcnt_q <= '0;
    end else if (done_o) begin
      opcnt_q <= opcnt_q + 32'h00000001;
    end
  end

  assign acc_o = acc_q;
  assign flags_o = flags_q;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_full_q && w_full_q && (state_q != S_EXEC);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= XMD_RESP_OKAY;
    end else begin
      if (aw_take) begin
        wr_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      aw_full_q <= (aw_full_q || aw_take) && !wr_fire;
      w_full_q <= (w_full_q || w_take) && !wr_fire;
      s_axi_awready <= !(aw_full_q || aw_take) && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !(w_full_q || w_take) && !s_axi_bvalid && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr_q) ? XMD_RESP_OKAY : XMD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= XMD_RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_take && !(s_axi_rvalid && !s_axi_rready);
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? XMD_RESP_OKAY : XMD_RESP_SLVERR;
        unique case (s_axi_araddr)
          XMD_REG_CTRL: s_axi_rdata <= {31'h0, en_q};
          XMD_REG_ACC: s_axi_rdata <= {24'h0, acc_q};
          XMD_REG_FLAGS: s_axi_rdata <= {26'h0, flags_q};
          XMD_REG_STATUS: s_axi_rdata <= {30'h0, last_skip_q, state_q != S_IDLE};
          XMD_REG_OPCNT: s_axi_rdata <= opcnt_q;
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  logic ex;
  assign ex = (state_q == S_EXEC);

  AST_CLEAR: assert property (ex && req_q.op == FAR_CLEAR_OP |=>
      mem_wr_o.we && mem_wr_o.data == 8'h00 && $stable(flags_q)) else $error("clear result wrong");
  AST_SET_BIT: assert property (ex && req_q.op == FAR_SET_BIT_OP |=>
      mem_wr_o.we && mem_wr_o.data[$past(req_q.bit_sel)] && $stable(flags_q)) else $error("set bit wrong");
  AST_INVERT_ACC: assert property (ex && req_q.op == FAR_INVERT_TO_ACC_OP |=>
      !mem_wr_o.we && acc_q == ~$past(req_q.mem_data) && flags_q.zero_flag == (acc_q == 8'h00))
      else $error("invert to accumulator wrong");
  AST_INC_ZERO: assert property (ex && req_q.op == FAR_INCREMENT_OP |=>
      mem_wr_o.data == $past(req_q.mem_data) + 8'h01 && flags_q.zero_flag == (mem_wr_o.data == 8'h00))
      else $error("increment wrong");
  AST_MOVE: assert property (ex && req_q.op == FAR_MOVE_TO_ACC_OP |=>
      acc_q == $past(req_q.mem_data) && $stable(flags_q) && !mem_wr_o.we) else $error("move wrong");
  AST_RLC: assert property (ex && req_q.op == FAR_ROTATE_LEFT_THRU_CARRY_OP |=>
      flags_q.carry_flag == $past(req_q.mem_data[7]) && mem_wr_o.data[0] == $past(flags_q.carry_flag))
      else $error("rotate left through carry wrong");
  AST_SBC_CARRY: assert property (ex && req_q.op == FAR_SUBTRACT_BORROW_OP |=>
      flags_q.carry_flag == ({1'b0, $past(acc_q)} >= {1'b0, $past(req_q.mem_data)} + {8'h00, !$past(flags_q.carry_flag)}))
      else $error("subtract carry wrong");
  AST_SKIP_THREE: assert property (ex && is_skip_op(req_q.op) |=>
      state_q == S_DUMMY1 ##1 state_q == S_DUMMY2 ##1 done_o) else $error("skip op not three cycles");
  AST_SKIP_ZERO: assert property (ex && req_q.op == FAR_DECREMENT_SKIP_ZERO_OP && req_q.mem_data == 8'h01 |=>
      $stable(flags_q) ##2 skip_next_o) else $error("skip on zero missing");
  AST_WRITE_ADDR: assert property (ex && wr_mem |=>
      mem_wr_o.addr == $past(req_q.addr)) else $error("write address wrong");

  COV_SKIP: cover property (skip_next_o);
  COV_SBC: cover property (ex && req_q.op == FAR_SUBTRACT_BORROW_TO_MEM_OP);
  COV_DAA: cover property (ex && req_q.op == FAR_DECIMAL_ADJUST_OP && lo_adj && hi_adj);
  COV_BUS: cover property (s_axi_bvalid && s_axi_bready);
endmodule // xmd_datapath
`default_nettype wire

// >>> xmd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module xmd_mem_model (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire xmd_pkg::xmd_mem_wr_t mem_wr_i,
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic [15:0] last_addr_o,
  output logic [7:0] wr_cnt_o
);
  import xmd_pkg::*;
  // ----------------------------------------
  // Data memory seen by the sequencer
  // ----------------------------------------
  // Only the low address byte indexes the array; the full address is kept apart so sections can be told apart.
  logic [7:0] mem_q [256];
  logic [15:0] last_addr_q;
  logic [7:0] wr_cnt_q;
  always_ff @(posedge ref_clk_i) begin
    if (mem_wr_i.we) begin
      mem_q[mem_wr_i.addr[7:0]] <= mem_wr_i.data;
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_addr_q <= 16'h0000;
      wr_cnt_q <= 8'h00;
    end else if (mem_wr_i.we) begin
      last_addr_q <= mem_wr_i.addr;
      wr_cnt_q <= wr_cnt_q + 8'h01;
    end
  end
  assign rd_data_o = mem_q[rd_addr_i[7:0]];
  assign last_addr_o = last_addr_q;
  assign wr_cnt_o = wr_cnt_q;
endmodule // xmd_mem_model
`default_nettype wire

// >>> xmd_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module xmd_datapath_tb_top;
  import xmd_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    xmd_op_t op;
    logic [2:0] bs;
    logic [7:0] acc;
    logic [5:0] fl;
    logic [7:0] m;
    logic [7:0] ex;
    logic tm;
    logic [5:0] ef;
    logic sk;
  } xmd_row_t;
  logic ref_clk, resetn, op_valid, op_ready, done, skip;
  xmd_req_t req;
  xmd_mem_wr_t wr;
  logic [7:0] acc, mem_rd, wcnt;
  logic [15:0] last_addr;
  xmd_flags_t flags;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int err_total = 0;
  int n_checks = 0;
  xmd_row_t rows [30] = '{
    '{FAR_CLEAR_OP, 3'h0, 8'h00, 6'h3F, 8'h12, 8'h00, 1'b1, 6'h3F, 1'b0},
    '{FAR_CLEAR_BIT_OP, 3'h7, 8'h00, 6'h00, 8'hFF, 8'h7F, 1'b1, 6'h00, 1'b0},
    '{FAR_SET_OP, 3'h0, 8'h00, 6'h00, 8'h12, 8'hFF, 1'b1, 6'h00, 1'b0},
    '{FAR_SET_BIT_OP, 3'h0, 8'h00, 6'h3F, 8'h00, 8'h01, 1'b1, 6'h3F, 1'b0},
    '{FAR_INVERT_OP, 3'h0, 8'h00, 6'h3B, 8'hFF, 8'h00, 1'b1, 6'h3F, 1'b0},
    '{FAR_INVERT_TO_ACC_OP, 3'h0, 8'h00, 6'h04, 8'h0F, 8'hF0, 1'b0, 6'h00, 1'b0},
    '{FAR_DECIMAL_ADJUST_OP, 3'h0, 8'hA5, 6'h02, 8'h00, 8'h0B, 1'b1, 6'h03, 1'b0},
    '{FAR_DECREMENT_OP, 3'h0, 8'h00, 6'h00, 8'h01, 8'h00, 1'b1, 6'h04, 1'b0},
    '{FAR_DECREMENT_TO_ACC_OP, 3'h0, 8'h11, 6'h3F, 8'h00, 8'hFF, 1'b0, 6'h3B, 1'b0},
    '{FAR_INCREMENT_OP, 3'h0, 8'h00, 6'h00, 8'hFF, 8'h00, 1'b1, 6'h04, 1'b0},
    '{FAR_INCREMENT_TO_ACC_OP, 3'h0, 8'h00, 6'h04, 8'h7F, 8'h80, 1'b0, 6'h00, 1'b0},
    '{FAR_MOVE_TO_ACC_OP, 3'h0, 8'h55, 6'h00, 8'h00, 8'h00, 1'b0, 6'h00, 1'b0},
    '{FAR_MOVE_TO_MEM_OP, 3'h0, 8'h5A, 6'h3F, 8'h00, 8'h5A, 1'b1, 6'h3F, 1'b0},
    '{FAR_BITWISE_UNION_OP, 3'h0, 8'h00, 6'h00, 8'h00, 8'h00, 1'b0, 6'h04, 1'b0},
    '{FAR_BITWISE_UNION_TO_MEM_OP, 3'h0, 8'h50, 6'h04, 8'h0A, 8'h5A, 1'b1, 6'h00, 1'b0},
    '{FAR_ROTATE_LEFT_OP, 3'h0, 8'h00, 6'h00, 8'h81, 8'h03, 1'b1, 6'h00, 1'b0},
    '{FAR_ROTATE_LEFT_TO_ACC_OP, 3'h0, 8'h00, 6'h01, 8'h40, 8'h80, 1'b0, 6'h01, 1'b0},
    '{FAR_ROTATE_LEFT_THRU_CARRY_OP, 3'h0, 8'h00, 6'h00, 8'h80, 8'h00, 1'b1, 6'h01, 1'b0},
    '{FAR_ROTATE_LEFT_THRU_CARRY_ACC_OP, 3'h0, 8'h00, 6'h01, 8'h01, 8'h03, 1'b0, 6'h00, 1'b0},
    '{FAR_ROTATE_RIGHT_OP, 3'h0, 8'h00, 6'h00, 8'h01, 8'h80, 1'b1, 6'h00, 1'b0},
    '{FAR_ROTATE_RIGHT_TO_ACC_OP, 3'h0, 8'h00, 6'h3F, 8'h02, 8'h01, 1'b0, 6'h3F, 1'b0},
    '{FAR_ROTATE_RIGHT_THRU_CARRY_OP, 3'h0, 8'h00, 6'h00, 8'h01, 8'h00, 1'b1, 6'h01, 1'b0},
    '{FAR_ROTATE_RIGHT_THRU_CARRY_ACC_OP, 3'h0, 8'h00, 6'h01, 8'h00, 8'h80, 1'b0, 6'h00, 1'b0},
    '{FAR_SUBTRACT_BORROW_OP, 3'h0, 8'h05, 6'h21, 8'h03, 8'h02, 1'b0, 6'h03, 1'b0},
    '{FAR_SUBTRACT_BORROW_TO_MEM_OP, 3'h0, 8'h05, 6'h00, 8'h05, 8'hFF, 1'b1, 6'h10, 1'b0},
    '{FAR_SUBTRACT_BORROW_OP, 3'h0, 8'h07, 6'h21, 8'h07, 8'h00, 1'b0, 6'h27, 1'b0},
    '{FAR_DECREMENT_SKIP_ZERO_OP, 3'h0, 8'h00, 6'h00, 8'h01, 8'h00, 1'b1, 6'h00, 1'b1},
    '{FAR_DECREMENT_SKIP_ZERO_ACC_OP, 3'h0, 8'h00, 6'h3F, 8'h05, 8'h04, 1'b0, 6'h3F, 1'b0},
    '{FAR_INCREMENT_SKIP_ZERO_OP, 3'h0, 8'h00, 6'h00, 8'hFF, 8'h00, 1'b1, 6'h00, 1'b1},
    '{FAR_INCREMENT_SKIP_ZERO_OP, 3'h0, 8'h00, 6'h00, 8'h10, 8'h11, 1'b1, 6'h00, 1'b0}
  };
  xmd_datapath i_xmd_datapath (.ref_clk_i(ref_clk), .resetn_i(resetn), .op_valid_i(op_valid),
    .op_ready_o(op_ready), .op_req_i(req), .mem_wr_o(wr), .done_o(done), .skip_next_o(skip),
    .acc_o(acc), .flags_o(flags), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  xmd_mem_model i_xmd_mem_model (.ref_clk_i(ref_clk), .resetn_i(resetn), .mem_wr_i(wr),
    .rd_addr_i(req.addr), .rd_data_o(mem_rd), .last_addr_o(last_addr), .wr_cnt_o(wcnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Counts edges from the taking edge until done is sampled high.
  task automatic run_op(input xmd_row_t rw, input logic [15:0] a, output int n, output logic sk);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    req <= '{op: rw.op, bit_sel: rw.bs, addr: a, mem_data: rw.m};
    do @(posedge ref_clk); while (!(op_valid && op_ready));
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!done && n < 20);
    sk = skip;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    logic sk;
    logic [7:0] wc;
    logic [15:0] a;
    resetn = 1'b0;
    op_valid = 1'b0;
    req = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    chk_v(32'({acc, flags}), 32'h0);
    resetn <= 1'b1;
    axi_rd(XMD_REG_CTRL, d, r);
    chk_v(d, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      axi_wr(XMD_REG_ACC, 32'(rows[i].acc), r);
      axi_wr(XMD_REG_FLAGS, 32'(rows[i].fl), r);
      wc = wcnt;
      a = {i[7:0], 8'h3C};
      run_op(rows[i], a, n, sk);
      @(negedge ref_clk);
      chk_v(32'(n), (rows[i].op >= FAR_DECREMENT_SKIP_ZERO_OP) ? 32'h4 : 32'h2);
      chk_v(32'(sk), 32'(rows[i].sk));
      chk_v(32'(flags), 32'(rows[i].ef));
      chk_v(32'(acc), 32'(rows[i].tm ? rows[i].acc : rows[i].ex));
      chk_v(32'(wcnt - wc), 32'(rows[i].tm));
      if (rows[i].tm) begin
        chk_v(32'(mem_rd), 32'(rows[i].ex));
        chk_v(32'(last_addr), 32'(a));
      end
      $display("test row %0d done", i);
    end
    axi_rd(XMD_REG_OPCNT, d, r);
    chk_v(d, 32'h1E);
    axi_wr(8'h40, 32'hFF, r);
    chk_v(32'(r), 32'(XMD_RESP_SLVERR));
    axi_rd(8'h44, d, r);
    chk_v(d, 32'h0);
    chk_v(32'(r), 32'(XMD_RESP_SLVERR));
    $display("test unmapped done");
    axi_wr(XMD_REG_CTRL, 32'h0, r);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    req <= '{op: FAR_INCREMENT_TO_ACC_OP, bit_sel: 3'h0, addr: 16'h0001, mem_data: 8'h41};
    repeat (6) @(posedge ref_clk);
    chk_v(32'({op_ready, done, acc}), 32'h00); // Held request must wait while execution is off.
    op_valid <= 1'b0;
    axi_wr(XMD_REG_CTRL, 32'h1, r);
    run_op('{FAR_INCREMENT_TO_ACC_OP, 3'h0, 8'h00, 6'h00, 8'h41, 8'h42, 1'b0, 6'h00, 1'b0}, 16'h0001, n, sk);
    @(negedge ref_clk);
    chk_v(32'(acc), 32'h42);
    $display("test enable done");
    resetn <= 1'b0;
    @(posedge ref_clk);
    chk_v(32'({acc, flags, op_ready, done}), 32'h0); // Outputs return to their reset values.
    resetn <= 1'b1;
    axi_rd(XMD_REG_OPCNT, d, r);
    chk_v(d, 32'h0);
    $display("test midreset done");
    test_done;
  end
endmodule // xmd_datapath_tb_top
`default_nettype wire
